// ### hw/tbsc_stall_ctrl.sv
// stall control for the tightly-coupled SRAMs and the AHB master
`timescale 1ns/1ns
// Summary of operation
// - isolated instruction-SRAM fetches never stall
// - load plus fetch on instruction SRAM: one stall
// - fetch beside final load-multiple word: one stall
// - instruction-SRAM store with fetch: two stalls
// - access after instruction-SRAM store: one stall
// - store after store with fetch: two stalls
// - fetch at final store-multiple word: two stalls
// - isolated data SRAM loads never stall
// - data SRAM store streams never stall
// - data SRAM load after store: one stall
// - SRAM stalls counted in core cycles only
// - unbuffered bus accesses stall core until done
// - bus transfers start only with grant held
// - address driven only on bus edge strobe
// - stay synchronized across grouped bus transfers
// - ratio one, strobe high: no sync wait
// - back-to-back singles: each NONSEQ then IDLE
// - fetch NONSEQ replaces idle after single access
// - bursts end one IDLE, loads two
// - fetch NONSEQ replaces final burst idle
// - 1KB crossing restarts burst with NONSEQ
// - loads and fetches wait for write buffer drain
// - stalls drive the core clock gate low
module tbsc_stall_ctrl (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  // instruction fetch request from the core
  input  wire logic        IF_REQ_I,
  input  wire logic        IF_AHB_I,
  input  wire logic [31:0] IF_ADDR_I,
  // data request from the core
  input  wire logic        D_REQ_I,
  input  wire logic [1:0]  D_SEL_I,
  input  wire logic        D_WRITE_I,
  input  wire logic        D_BUFFERABLE_I,
  input  wire logic        D_MULTI_I,
  input  wire logic        D_LAST_I,
  input  wire logic [31:0] D_ADDR_I,
  // write buffer state
  input  wire logic        WB_EMPTY_I,
  // core stall
  output logic             CORE_CLOCK_GATE_O,
  // AHB master side
  input  wire logic        BUS_EDGE_STROBE_I,
  input  wire logic        HGRANT_I,
  input  wire logic        HREADY_I,
  output logic             HBUSREQ_O,
  output logic [1:0]       HTRANS_O,
  output logic [31:0]      HADDR_O,
  output logic             HWRITE_O
);

  typedef enum logic [2:0] {
    BS_IDLE,
    BS_ADDR,
    BS_DATA,
    BS_TAIL,
    BS_HOLD
  } tbsc_bus_state_t;

  // stall count for the SRAM side of one access
  function automatic logic [1:0] tcm_stalls(
    input logic f_i,
    input logic d_i,
    input logic wr,
    input logic pend_i,
    input logic d_d,
    input logic pend_d
  );
    logic [1:0] k;
    k = tbsc_pkg::CNT_ZERO;
    if (d_i && wr && f_i) begin
      k = tbsc_pkg::CNT_TWO;
    end else if (pend_i && (f_i || d_i)) begin
      k = tbsc_pkg::CNT_ONE;
    end else if (d_i && !wr && f_i) begin
      k = tbsc_pkg::CNT_ONE;
    end else if (d_d && !wr && pend_d) begin
      k = tbsc_pkg::CNT_ONE;
    end
    return k;
  endfunction

  // request decode
  logic             f_isram;
  logic             f_ahb;
  logic             d_isram;
  logic             d_dsram;
  logic             d_ahb;
  logic             ahb_need;
  logic             core_gate;

  assign f_isram  = IF_REQ_I && !IF_AHB_I;
  assign f_ahb    = IF_REQ_I && IF_AHB_I;
  assign d_isram  = D_REQ_I && (D_SEL_I == tbsc_pkg::TGT_ISRAM);
  assign d_dsram  = D_REQ_I && (D_SEL_I == tbsc_pkg::TGT_DSRAM);
  // buffered stores go straight to the write buffer and never stall here
  assign d_ahb    = D_REQ_I && (D_SEL_I == tbsc_pkg::TGT_AHB)
                    && !(D_WRITE_I && D_BUFFERABLE_I);
  assign ahb_need = d_ahb || f_ahb;

  // sram side state
  logic [1:0]       cnt_r;
  logic [1:0]       cnt_nxt;
  logic             paid_r;
  logic             paid_nxt;
  logic             pend_i_r;
  logic             pend_i_nxt;
  logic             pend_d_r;
  logic             pend_d_nxt;
  logic             eval;
  logic [1:0]       tcm_k;
  logic             tcm_ok;

  // a fresh access is judged once; the core holds it while frozen
  assign eval   = (cnt_r == tbsc_pkg::CNT_ZERO) && !paid_r;
  assign tcm_k  = eval ? tcm_stalls(f_isram, d_isram, D_WRITE_I, pend_i_r,
                                    d_dsram, pend_d_r)
                       : tbsc_pkg::CNT_ZERO;
  assign tcm_ok = (cnt_r == tbsc_pkg::CNT_ZERO)
                  && (paid_r || (tcm_k == tbsc_pkg::CNT_ZERO));

  always_comb begin
    cnt_nxt  = cnt_r;
    paid_nxt = paid_r;
    if (cnt_r != tbsc_pkg::CNT_ZERO) begin
      cnt_nxt = cnt_r - tbsc_pkg::CNT_ONE;
    end else if (eval && (tcm_k != tbsc_pkg::CNT_ZERO)) begin
      cnt_nxt  = tcm_k - tbsc_pkg::CNT_ONE;
      paid_nxt = 1'b1;
    end
    if (core_gate) begin
      paid_nxt = 1'b0;
    end
    // a second write cycle finishes in the next cycle, stalled or not
    pend_i_nxt = core_gate && d_isram && D_WRITE_I && !f_isram;
    pend_d_nxt = core_gate && d_dsram && D_WRITE_I;
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cnt_r    <= tbsc_pkg::CNT_ZERO;
      paid_r   <= 1'b0;
      pend_i_r <= 1'b0;
      pend_d_r <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      paid_r   <= paid_nxt;
      pend_i_r <= pend_i_nxt;
      pend_d_r <= pend_d_nxt;
    end
  end

  // bus side state
  tbsc_bus_state_t  bs_r;
  tbsc_bus_state_t  bs_nxt;
  logic             cur_fetch_r;
  logic             cur_fetch_nxt;
  logic             fetch_pend_r;
  logic             fetch_pend_nxt;
  logic             brk_r;
  logic             brk_nxt;
  logic [1:0]       tails_r;
  logic [1:0]       tails_nxt;
  logic             served_r;
  logic             served_nxt;
  logic [1:0]       htrans_r;
  logic [1:0]       htrans_nxt;
  logic [31:0]      haddr_r;
  logic [31:0]      haddr_nxt;
  logic             hwrite_r;
  logic             hwrite_nxt;
  logic             fin;
  logic             st;
  logic             ld_multi;
  localparam int    REGION_BITS_M1 = tbsc_pkg::REGION_BITS - 1;

  assign st       = BUS_EDGE_STROBE_I;
  assign ld_multi = D_MULTI_I && !D_WRITE_I;

  always_comb begin
    bs_nxt         = bs_r;
    cur_fetch_nxt  = cur_fetch_r;
    fetch_pend_nxt = fetch_pend_r;
    brk_nxt        = brk_r;
    tails_nxt      = tails_r;
    htrans_nxt     = htrans_r;
    haddr_nxt      = haddr_r;
    hwrite_nxt     = hwrite_r;
    fin            = 1'b0;
    unique case (bs_r)
      BS_IDLE: begin
        // with strobe high in the request cycle there is no sync wait
        if (ahb_need && !served_r && WB_EMPTY_I && HGRANT_I && st) begin
          bs_nxt     = BS_ADDR;
          brk_nxt    = 1'b0;
          htrans_nxt = tbsc_pkg::TRANS_NONSEQ;
          if (d_ahb) begin
            haddr_nxt      = D_ADDR_I;
            hwrite_nxt     = D_WRITE_I;
            cur_fetch_nxt  = 1'b0;
            fetch_pend_nxt = f_ahb;
          end else begin
            haddr_nxt      = IF_ADDR_I;
            hwrite_nxt     = 1'b0;
            cur_fetch_nxt  = 1'b1;
            fetch_pend_nxt = 1'b0;
          end
        end
      end
      BS_ADDR: begin
        if (st) begin
          htrans_nxt = tbsc_pkg::TRANS_IDLE;
          bs_nxt     = BS_DATA;
        end
      end
      BS_DATA: begin
        if (st && HREADY_I) begin
          if (cur_fetch_r) begin
            tails_nxt = tbsc_pkg::CNT_ONE;
            bs_nxt    = BS_TAIL;
          end else if (D_MULTI_I && !D_LAST_I) begin
            fin    = 1'b1;
            bs_nxt = BS_HOLD;
          end else if (fetch_pend_r && !ld_multi) begin
            htrans_nxt     = tbsc_pkg::TRANS_NONSEQ;
            haddr_nxt      = IF_ADDR_I;
            hwrite_nxt     = 1'b0;
            cur_fetch_nxt  = 1'b1;
            fetch_pend_nxt = 1'b0;
            bs_nxt         = BS_ADDR;
          end else begin
            tails_nxt = ld_multi ? tbsc_pkg::CNT_TWO
                                 : tbsc_pkg::CNT_ONE;
            bs_nxt    = BS_TAIL;
          end
        end
      end
      BS_TAIL: begin
        if (st) begin
          if (tails_r == tbsc_pkg::CNT_ONE) begin
            if (brk_r) begin
              htrans_nxt    = tbsc_pkg::TRANS_NONSEQ;
              haddr_nxt     = D_ADDR_I;
              hwrite_nxt    = D_WRITE_I;
              cur_fetch_nxt = 1'b0;
              brk_nxt       = 1'b0;
              bs_nxt        = BS_ADDR;
            end else begin
              fin    = 1'b1;
              bs_nxt = BS_IDLE;
            end
          end else if (fetch_pend_r && !brk_r) begin
            htrans_nxt     = tbsc_pkg::TRANS_NONSEQ;
            haddr_nxt      = IF_ADDR_I;
            hwrite_nxt     = 1'b0;
            cur_fetch_nxt  = 1'b1;
            fetch_pend_nxt = 1'b0;
            bs_nxt         = BS_ADDR;
          end else begin
            tails_nxt = tbsc_pkg::CNT_ONE;
          end
        end
      end
      BS_HOLD: begin
        if (!served_r && !d_ahb) begin
          bs_nxt = BS_IDLE;
        end else if (!served_r && st && HGRANT_I) begin
          fetch_pend_nxt = f_ahb;
          if (D_ADDR_I[REGION_BITS_M1:0] == '0) begin
            brk_nxt   = 1'b1;
            tails_nxt = D_WRITE_I ? tbsc_pkg::CNT_ONE : tbsc_pkg::CNT_TWO;
            bs_nxt    = BS_TAIL;
          end else begin
            htrans_nxt = tbsc_pkg::TRANS_SEQ;
            haddr_nxt  = D_ADDR_I;
            hwrite_nxt = D_WRITE_I;
            bs_nxt     = BS_ADDR;
          end
        end
      end
    endcase
    // completion is held until the core actually takes it
    served_nxt = core_gate ? 1'b0 : (served_r || fin);
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      bs_r         <= BS_IDLE;
      cur_fetch_r  <= 1'b0;
      fetch_pend_r <= 1'b0;
      brk_r        <= 1'b0;
      tails_r      <= tbsc_pkg::CNT_ZERO;
      served_r     <= 1'b0;
      htrans_r     <= tbsc_pkg::TRANS_IDLE;
      haddr_r      <= tbsc_pkg::ADDR_RESET;
      hwrite_r     <= 1'b0;
    end else begin
      bs_r         <= bs_nxt;
      cur_fetch_r  <= cur_fetch_nxt;
      fetch_pend_r <= fetch_pend_nxt;
      brk_r        <= brk_nxt;
      tails_r      <= tails_nxt;
      served_r     <= served_nxt;
      htrans_r     <= htrans_nxt;
      haddr_r      <= haddr_nxt;
      hwrite_r     <= hwrite_nxt;
    end
  end

  assign core_gate = tcm_ok && (!ahb_need || served_r);

  assign CORE_CLOCK_GATE_O = core_gate;
  assign HBUSREQ_O         = (ahb_need && !served_r) || (bs_r != BS_IDLE);
  assign HTRANS_O          = htrans_r;
  assign HADDR_O           = haddr_r;
  assign HWRITE_O          = hwrite_r;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence s_one_stall;
    !core_gate ##1 (cnt_r == tbsc_pkg::CNT_ZERO) && paid_r;
  endsequence

  sequence s_two_stall;
    !core_gate ##1 !core_gate ##1 (cnt_r == tbsc_pkg::CNT_ZERO) && paid_r;
  endsequence

  a_fetch_no_stall: assert property (
    eval && f_isram && !D_REQ_I && !pend_i_r && !ahb_need |-> core_gate)
    else $error("lone sram fetch stalled");
  a_load_fetch_one: assert property (
    eval && f_isram && d_isram && !D_WRITE_I && !pend_i_r |-> s_one_stall)
    else $error("load with fetch not one stall");
  a_store_fetch_two: assert property (
    eval && f_isram && d_isram && D_WRITE_I |-> s_two_stall)
    else $error("store with fetch not two stalls");
  a_store_after_one: assert property (
    eval && pend_i_r && (f_isram || d_isram)
    && !(f_isram && d_isram && D_WRITE_I) |-> tcm_k == tbsc_pkg::CNT_ONE)
    else $error("access after sram store not one stall");
  a_dsram_no_stall: assert property (
    eval && d_dsram && !pend_i_r && !(pend_d_r && !D_WRITE_I)
    |-> tcm_k == tbsc_pkg::CNT_ZERO)
    else $error("data sram access stalled");
  a_dsram_ld_st: assert property (
    eval && d_dsram && !D_WRITE_I && pend_d_r |-> s_one_stall)
    else $error("data load after store not one stall");
  a_ahb_stalls: assert property (
    ahb_need && !served_r |-> !core_gate)
    else $error("core ran during bus access");
  a_start_strobe: assert property (
    htrans_r != tbsc_pkg::TRANS_IDLE
    && $past(htrans_r) == tbsc_pkg::TRANS_IDLE |-> $past(BUS_EDGE_STROBE_I))
    else $error("transfer started off the bus edge");
  a_bus_hold: assert property (
    htrans_r != tbsc_pkg::TRANS_IDLE && !BUS_EDGE_STROBE_I
    |=> $stable(htrans_r) && $stable(haddr_r))
    else $error("address phase changed between bus edges");
  a_wb_drain: assert property (
    bs_r == BS_IDLE && !WB_EMPTY_I |=> bs_r == BS_IDLE)
    else $error("bus started before write buffer drained");
endmodule // tbsc_stall_ctrl

// ### include/tbsc_pkg.sv
// constants shared by the tightly-coupled memory and bus stall controller
package tbsc_pkg;
  // target of a data-side access
  localparam logic [1:0] TGT_DSRAM    = 2'h0;
  localparam logic [1:0] TGT_ISRAM    = 2'h1;
  localparam logic [1:0] TGT_AHB      = 2'h2;
  // AHB transfer type encodings
  localparam logic [1:0] TRANS_IDLE   = 2'h0;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [1:0] TRANS_SEQ    = 2'h3;
  // stall and idle counts
  localparam logic [1:0] CNT_ZERO     = 2'h0;
  localparam logic [1:0] CNT_ONE      = 2'h1;
  localparam logic [1:0] CNT_TWO      = 2'h2;
  // address bits below a 1KB region boundary
  localparam int         REGION_BITS  = 10;
  localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;
endpackage : tbsc_pkg

// ### sim/tbsc_ahb_model.sv
// arbiter and slave model on the far side of the bus master
`timescale 1ns/1ns
module tbsc_ahb_model (
  // clock, reset and bus edge strobe
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        strobe_i,
  // master outputs
  input  wire logic [1:0]  htrans_i,
  input  wire logic [31:0] haddr_i,
  // bench control: grant and data phase wait states
  input  wire logic        grant_en_i,
  input  wire logic [1:0]  wait_i,
  // to master and bench
  output logic             hgrant_o,
  output logic             hready_o,
  output logic [31:0]      nseq_o,
  output logic [31:0]      seq_o,
  output logic [31:0]      bad_o,
  output logic [31:0]      addr_o
);
  logic [1:0] wcnt_r;
  logic [1:0] tr_d_r;
  logic       stb_d_r;
  // default master: grant held unless the bench withdraws it
  assign hgrant_o = grant_en_i;
  assign hready_o = (wcnt_r == 2'h0);
  always @(posedge clk_i) begin
    stb_d_r <= strobe_i;
    tr_d_r <= htrans_i;
    if (!rst_n_i) begin
      wcnt_r <= 2'h0;
      nseq_o <= 32'h0;
      seq_o <= 32'h0;
      bad_o <= 32'h0;
      addr_o <= 32'h0;
    end else begin
      // transfer type may only move in the cycle after a bus edge
      if (htrans_i != tr_d_r && !stb_d_r)
        bad_o <= bad_o + 32'h1;
      if (strobe_i && htrans_i == tbsc_pkg::TRANS_NONSEQ)
        nseq_o <= nseq_o + 32'h1;
      if (strobe_i && htrans_i == tbsc_pkg::TRANS_SEQ)
        seq_o <= seq_o + 32'h1;
      if (strobe_i && htrans_i != tbsc_pkg::TRANS_IDLE) begin
        wcnt_r <= wait_i;
        addr_o <= haddr_i;
      end else if (strobe_i && wcnt_r != 2'h0)
        wcnt_r <= wcnt_r - 2'h1;
    end
  end
endmodule // tbsc_ahb_model

// ### sim/tbsc_stall_ctrl_test.sv
// self-checking bench for the stall controller
`timescale 1ns/1ns
module tbsc_stall_ctrl_test;
  localparam logic [1:0] DS = tbsc_pkg::TGT_DSRAM;
  localparam logic [1:0] IS = tbsc_pkg::TGT_ISRAM;
  localparam logic [1:0] AH = tbsc_pkg::TGT_AHB;
  logic        clk = 1'b0, rst_n = 1'b0, if_req = 1'b0, if_ahb = 1'b0;
  logic        d_req = 1'b0, d_write = 1'b0, d_buf = 1'b0, d_multi = 1'b0;
  logic        d_last = 1'b0, wb_empty = 1'b1, strobe = 1'b1;
  logic        grant_en = 1'b1, gate, hgrant, hready, hbusreq, hwrite;
  logic [1:0]  d_sel = 2'h0, wait_n = 2'h0, htrans;
  logic [31:0] if_addr = 32'h0, d_addr = 32'h0, haddr, nseq, seq, bad, maddr;
  int          ratio = 1, scnt = 0, n_errors = 0, samples_checked = 0;

  always #5 clk = ~clk;
  // strobe marks the last core cycle of each bus cycle
  always @(negedge clk) begin
    scnt = (scnt + 1) % ratio;
    strobe <= (scnt == 0);
  end

  tbsc_stall_ctrl tbsc_stall_ctrl_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .IF_REQ_I(if_req), .IF_AHB_I(if_ahb),
    .IF_ADDR_I(if_addr), .D_REQ_I(d_req), .D_SEL_I(d_sel),
    .D_WRITE_I(d_write), .D_BUFFERABLE_I(d_buf), .D_MULTI_I(d_multi),
    .D_LAST_I(d_last), .D_ADDR_I(d_addr), .WB_EMPTY_I(wb_empty),
    .CORE_CLOCK_GATE_O(gate), .BUS_EDGE_STROBE_I(strobe),
    .HGRANT_I(hgrant), .HREADY_I(hready), .HBUSREQ_O(hbusreq),
    .HTRANS_O(htrans), .HADDR_O(haddr), .HWRITE_O(hwrite));
  tbsc_ahb_model tbsc_ahb_model_inst (
    .clk_i(clk), .rst_n_i(rst_n), .strobe_i(strobe), .htrans_i(htrans),
    .haddr_i(haddr), .grant_en_i(grant_en), .wait_i(wait_n),
    .hgrant_o(hgrant), .hready_o(hready), .nseq_o(nseq), .seq_o(seq),
    .bad_o(bad), .addr_o(maddr));

  task automatic check(input logic [31:0] seen, input int exp);
    samples_checked++;
    if (seen !== 32'(exp)) begin
      n_errors++;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic idle(input int n);
    if_req = 1'b0;
    d_req = 1'b0;
    repeat (n) @(negedge clk);
  endtask

  task automatic acc(input logic f, fa, d, input logic [1:0] s,
                     input logic w, m, l, input logic [31:0] a,
                     output int st);
    if_req = f;
    if_ahb = fa;
    if_addr = a + 32'h100;
    d_req = d;
    d_sel = s;
    d_write = w;
    d_multi = m;
    d_last = l;
    d_addr = a;
    st = 0;
    #1;
    // core holds its request for as long as the gate stays low
    while (gate !== 1'b1 && st < 400) begin
      @(negedge clk);
      #1;
      st++;
    end
    @(negedge clk);
  endtask

  task automatic t_isram;
    int st;
    for (int r = 1; r <= 3; r += 2) begin
      ratio = r;
      idle(2);
      acc(1, 0, 0, IS, 0, 0, 0, 32'h40, st);
      check(st, 0);
      acc(1, 0, 1, IS, 0, 0, 0, 32'h44, st);
      check(st, 1);
      acc(1, 0, 1, IS, 0, 1, 1, 32'h48, st);
      check(st, 1);
      acc(0, 0, 1, IS, 1, 0, 0, 32'h50, st);
      check(st, 0);
      acc(1, 0, 0, IS, 0, 0, 0, 32'h54, st);
      check(st, 1);
      acc(0, 0, 1, IS, 1, 0, 0, 32'h58, st);
      check(st, 0);
      acc(0, 0, 1, IS, 0, 0, 0, 32'h5c, st);
      check(st, 1);
      acc(0, 0, 1, IS, 1, 0, 0, 32'h60, st);
      check(st, 0);
      acc(1, 0, 1, IS, 1, 0, 0, 32'h64, st);
      check(st, 2);
      idle(1);
      acc(1, 0, 1, IS, 1, 0, 0, 32'h68, st);
      check(st, 2);
      idle(1);
      acc(1, 0, 1, IS, 1, 1, 1, 32'h6c, st);
      check(st, 2);
    end
  endtask

  task automatic t_dsram;
    int st;
    idle(2);
    acc(1, 0, 1, DS, 0, 0, 0, 32'h80, st);
    check(st, 0);
    acc(1, 0, 1, DS, 0, 1, 0, 32'h84, st);
    check(st, 0);
    acc(1, 0, 1, DS, 0, 1, 1, 32'h88, st);
    check(st, 0);
    acc(1, 0, 1, DS, 1, 0, 0, 32'h8c, st);
    check(st, 0);
    acc(1, 0, 1, DS, 1, 1, 0, 32'h90, st);
    check(st, 0);
    acc(1, 0, 1, DS, 1, 1, 1, 32'h94, st);
    check(st, 0);
    acc(1, 0, 1, DS, 0, 1, 0, 32'h98, st);
    check(st, 1);
  endtask

  task automatic single(input int r, input logic [1:0] wt);
    logic [31:0] n0;
    int st;
    ratio = r;
    wait_n = wt;
    idle(4);
    n0 = nseq;
    acc(0, 1, 1, AH, 0, 0, 0, 32'h2040, st);
    idle(8);
    // address, data with waits, one idle, one cycle to hand back
    check(st >= (3 + wt) * r + 1, 1);
    // plus at most ratio minus one cycles of sync wait
    check(st <= (4 + wt) * r, 1);
    check(nseq - n0, 1);
    check(maddr, 32'h2040);
    wait_n = 2'h0;
  endtask

  task automatic burst(input logic w, fe, input int n,
                       input logic [31:0] a, input int en, es);
    logic [31:0] n0, s0;
    int st;
    n0 = nseq;
    s0 = seq;
    for (int i = 0; i < n; i++)
      acc(fe && i == n - 1, 1, 1, AH, w, 1, i == n - 1, a + 32'(4 * i), st);
    idle(8);
    check(nseq - n0, en);
    check(seq - s0, es);
  endtask

  task automatic blocked(input logic g, wb);
    logic [31:0] n0;
    int st;
    n0 = nseq;
    grant_en = g;
    wb_empty = wb;
    d_req = 1'b1;
    d_sel = AH;
    d_write = 1'b0;
    d_multi = 1'b0;
    repeat (12) @(negedge clk);
    check(gate, 0);
    check(nseq - n0, 0);
    if (!g) check(hbusreq, 1);
    grant_en = 1'b1;
    wb_empty = 1'b1;
    acc(0, 0, 1, AH, 0, 0, 0, 32'h2080, st);
    idle(8);
    check(nseq - n0, 1);
  endtask

  task automatic t_ahb;
    logic [31:0] n0;
    int st;
    single(1, 2'h0);
    single(2, 2'h0);
    single(3, 2'h2);
    n0 = nseq;
    acc(0, 1, 1, AH, 0, 0, 0, 32'h2000, st);
    acc(0, 1, 1, AH, 1, 0, 0, 32'h2004, st);
    idle(8);
    check(nseq - n0, 2);
    // the last transfer was the store: its address and direction remain
    check(hwrite, 1);
    check(haddr, 32'h2004);
    n0 = nseq;
    acc(1, 1, 1, AH, 0, 0, 0, 32'h2010, st);
    idle(8);
    check(nseq - n0, 2);
    // fetch goes second, so its read address is the one left on the bus
    check(hwrite, 0);
    check(haddr, 32'h2110);
    burst(1, 0, 4, 32'h2100, 1, 3);
    burst(0, 1, 3, 32'h2200, 2, 2);
    burst(0, 0, 4, 32'h23f8, 2, 2);
    burst(1, 0, 4, 32'h27f8, 2, 2);
    d_buf = 1'b1;
    n0 = nseq;
    acc(0, 0, 1, AH, 1, 0, 0, 32'h2300, st);
    d_buf = 1'b0;
    check(st, 0);
    idle(8);
    check(nseq - n0, 0);
    blocked(1'b0, 1'b1);
    blocked(1'b1, 1'b0);
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    check(htrans, tbsc_pkg::TRANS_IDLE);
    check(gate, 1);
    check(hbusreq, 0);
    t_isram;
    t_dsram;
    t_ahb;
    check(bad, 0);
    finish_test;
  end

  // whole run is a few hundred cycles; this allows ample margin
  initial begin
    #500000;
    n_errors++;
    $display("BAD t=%0t run did not complete", $time);
    finish_test;
  end
endmodule // tbsc_stall_ctrl_test
